// ### core/spslv_top.sv
/*
  parallel slave port core: an external master writes an 8-bit input latch and
  reads an 8-bit output latch through active-low strobes; firmware uses wishbone registers.
  assumes strobes and data pins synchronous to sys_clk_i, pad logic outside.
*/
// What this block does
// - mode bit turns data pins into slave port
// - master reaches latch using strobes only
// - mode takes read, write, chip select inputs
// - write spans chip select and write low
// - write latches byte while held, end sets flag, full
// - read drives latch out, sets output full
// - firmware write during read drives, no full
// - read end releases pins, sets flag
// - bit 7 shows received byte waiting
// - bit 6 shows output byte being read
// - bit 5 overflow, cleared only by firmware
// - port works only without external bus mode
`timescale 1ns/100ps
module spslv_top (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // parallel port pins
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  pd_i,
  output logic      [7:0]  pd_o,
  output logic             pd_oe_o,
  // interrupt
  output logic             irq_o,
  output logic             irq_high_prio_o
);
  logic [7:0]  data_in_q;
  logic [7:0]  data_out_q;
  logic        ibf_q, obf_q, input_overflow_q, mode_q;
  logic [2:0]  irq_stat_q, irq_mask_q, strobe_dir_q;
  logic [1:0]  cfg_q;
  logic        active;
  logic        wr_low, rd_low;
  logic        wr_end, rd_start, rd_end;
  logic        bus_req, bus_wr, bus_rd, lane0;
  logic [2:0]  ev;
  logic [7:0]  stat_rd;
  logic [31:0] rd_d;
  spslv_pkg::spslv_state_t st_q;

  // port enabled only in mode and without the external bus
  assign active  = mode_q & ~cfg_q[spslv_pkg::BIT_CFG_EXT_BUS];
  assign wr_low  = active & ~cs_n_i & ~wr_n_i;
  assign rd_low  = active & ~cs_n_i & ~rd_n_i;
  assign wr_end  = (st_q == spslv_pkg::SPSLV_WRITE) & ~wr_low;
  assign rd_start = (st_q == spslv_pkg::SPSLV_IDLE) & ~wr_low & rd_low;
  assign rd_end  = (st_q == spslv_pkg::SPSLV_READ) & ~rd_low;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land at the edge where the master sees ack
  assign bus_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  assign bus_rd  = bus_req & ~wb_we_i;
  assign lane0   = wb_sel_i[0];

  // link state: transfers sampled on the system clock
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q <= spslv_pkg::SPSLV_IDLE;
    end else begin
      unique case (st_q)
        spslv_pkg::SPSLV_IDLE: begin
          if (wr_low) begin
            st_q <= spslv_pkg::SPSLV_WRITE;
          end else if (rd_low) begin
            st_q <= spslv_pkg::SPSLV_READ;
          end
        end
        spslv_pkg::SPSLV_WRITE: begin
          if (!wr_low) begin
            st_q <= spslv_pkg::SPSLV_IDLE;
          end
        end
        spslv_pkg::SPSLV_READ: begin
          if (!rd_low) begin
            st_q <= spslv_pkg::SPSLV_IDLE;
          end
        end
        default: st_q <= spslv_pkg::SPSLV_IDLE;
      endcase
    end
  end

  // input latch takes the byte while the write is held
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_in_q <= spslv_pkg::RST_DATA;
    end else if (st_q == spslv_pkg::SPSLV_WRITE && wr_low) begin
      data_in_q <= pd_i;
    end
  end

  // output latch written by firmware
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_out_q <= spslv_pkg::RST_DATA;
    end else if (bus_wr && lane0 && wb_adr_i == spslv_pkg::OFF_DATA) begin
      data_out_q <= wb_dat_i[7:0];
    end
  end

  // input full: set on write end wins over the firmware read clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ibf_q <= spslv_pkg::RST_CTRL_STAT[spslv_pkg::BIT_INPUT_FULL];
    end else if (wr_end) begin
      ibf_q <= 1'b1;
    end else if (bus_rd && wb_adr_i == spslv_pkg::OFF_DATA) begin
      ibf_q <= 1'b0;
    end
  end

  // output full: set at read start, firmware write during read leaves it
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      obf_q <= spslv_pkg::RST_CTRL_STAT[spslv_pkg::BIT_OUTPUT_FULL];
    end else if (rd_start) begin
      obf_q <= 1'b1;
    end else if (rd_end) begin
      obf_q <= 1'b0;
    end
  end

  // overflow, cleared only by firmware writing zero; set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      input_overflow_q <= spslv_pkg::RST_CTRL_STAT[spslv_pkg::BIT_INPUT_OVERFLOW];
    end else if (wr_end && ibf_q) begin
      input_overflow_q <= 1'b1;
    end else if (bus_wr && lane0 && wb_adr_i == spslv_pkg::OFF_CTRL_STAT) begin
      input_overflow_q <= input_overflow_q & wb_dat_i[spslv_pkg::BIT_INPUT_OVERFLOW];
    end
  end

  // mode, strobe direction and configuration
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode_q       <= spslv_pkg::RST_CTRL_STAT[spslv_pkg::BIT_MODE_SELECT];
      strobe_dir_q <= spslv_pkg::RST_STROBE_DIR;
      cfg_q        <= spslv_pkg::RST_CONFIG;
    end else if (bus_wr && lane0) begin
      if (wb_adr_i == spslv_pkg::OFF_CTRL_STAT) begin
        mode_q <= wb_dat_i[spslv_pkg::BIT_MODE_SELECT];
      end
      if (wb_adr_i == spslv_pkg::OFF_STROBE_DIR) begin
        strobe_dir_q <= wb_dat_i[2:0];
      end
      if (wb_adr_i == spslv_pkg::OFF_CONFIG) begin
        cfg_q <= wb_dat_i[1:0];
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign ev = {wr_end & ibf_q, rd_end, wr_end};
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= spslv_pkg::RST_IRQ;
      irq_mask_q <= spslv_pkg::RST_IRQ;
    end else begin
      if (bus_wr && lane0 && wb_adr_i == spslv_pkg::OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~wb_dat_i[2:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (bus_wr && lane0 && wb_adr_i == spslv_pkg::OFF_IRQ_MASK) begin
        irq_mask_q <= wb_dat_i[2:0];
      end
    end
  end

  // interrupt outputs registered
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_o           <= 1'b0;
      irq_high_prio_o <= 1'b0;
    end else begin
      irq_o           <= |(irq_stat_q & irq_mask_q);
      irq_high_prio_o <= (|(irq_stat_q & irq_mask_q)) & cfg_q[spslv_pkg::BIT_CFG_PRIORITY];
    end
  end

  // pin drive: pins follow firmware writes one cycle after the latch, also during a read
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pd_o    <= spslv_pkg::RST_DATA;
      pd_oe_o <= 1'b0;
    end else begin
      pd_o    <= data_out_q;
      pd_oe_o <= rd_low & ~wr_low;
    end
  end

  // register read mux
  assign stat_rd = {ibf_q, obf_q, input_overflow_q, mode_q, 4'h0};
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_adr_i)
      spslv_pkg::OFF_CTRL_STAT:  rd_d[7:0] = stat_rd;
      spslv_pkg::OFF_DATA:       rd_d[7:0] = data_in_q;
      spslv_pkg::OFF_IRQ_STAT:   rd_d[2:0] = irq_stat_q;
      spslv_pkg::OFF_IRQ_MASK:   rd_d[2:0] = irq_mask_q;
      spslv_pkg::OFF_STROBE_DIR: rd_d[2:0] = strobe_dir_q;
      spslv_pkg::OFF_CONFIG:     rd_d[1:0] = cfg_q;
      default:                   rd_d = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request, dropped the cycle after
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_d;
    end
  end

  // assertions
  property p_write_end_flags;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_end |=> ibf_q && irq_stat_q[spslv_pkg::BIT_IRQ_WRITE_END];
  endproperty
  a_write_end_flags: assert property (p_write_end_flags)
    else $error("write end did not set input full and flag");

  property p_read_drive;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_start |=> pd_oe_o && obf_q;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read start did not drive pins or set output full");

  property p_read_release;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_end |=> !pd_oe_o && irq_stat_q[spslv_pkg::BIT_IRQ_READ_END] ##1 !pd_oe_o;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("read end did not release pins or set flag");

  property p_overflow;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_end && ibf_q |=> input_overflow_q;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged");

  property p_inactive_quiet;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      !active |=> !pd_oe_o;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet)
    else $error("pins driven while port inactive");

  property p_irq_level;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      |(irq_stat_q & irq_mask_q) |=> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised");

  property p_data_read_clears;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      bus_rd && wb_adr_i == spslv_pkg::OFF_DATA && !wr_end
      |=> !ibf_q && wb_dat_o[7:0] == $past(data_in_q);
  endproperty
  a_data_read_clears: assert property (p_data_read_clears)
    else $error("data read did not clear input full");

  property p_write_latch;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_q == spslv_pkg::SPSLV_WRITE && wr_low |=> data_in_q == $past(pd_i);
  endproperty
  a_write_latch: assert property (p_write_latch)
    else $error("byte not latched during write");

  property p_status_bits;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      bus_rd && wb_adr_i == spslv_pkg::OFF_CTRL_STAT
      |=> wb_dat_o[7] == $past(ibf_q) && wb_dat_o[6] == $past(obf_q);
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status read wrong");

  property p_obf_hold_on_fw_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      st_q == spslv_pkg::SPSLV_READ && rd_low && bus_wr && lane0
        && wb_adr_i == spslv_pkg::OFF_DATA
      |=> obf_q == $past(obf_q) ##1 pd_o == $past(wb_dat_i[7:0], 2);
  endproperty
  a_obf_hold_on_fw_write: assert property (p_obf_hold_on_fw_write)
    else $error("output full set again during read");
endmodule

// ### core/spslv_pkg.sv
/*
  package for the parallel slave port: register offsets, field positions,
  reset values and the link state encoding.
  assumes a 32-bit classic wishbone register bus with byte addresses.
*/
package spslv_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_STAT = 8'h00;
  localparam logic [7:0] OFF_DATA      = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] OFF_STROBE_DIR = 8'h10;
  localparam logic [7:0] OFF_CONFIG    = 8'h14;
  // control/status field positions
  localparam int BIT_INPUT_FULL     = 7;
  localparam int BIT_OUTPUT_FULL    = 6;
  localparam int BIT_INPUT_OVERFLOW = 5;
  localparam int BIT_MODE_SELECT    = 4;
  // irq status / mask fields
  localparam int BIT_IRQ_WRITE_END  = 0;
  localparam int BIT_IRQ_READ_END   = 1;
  localparam int BIT_IRQ_OVERFLOW   = 2;
  // config fields
  localparam int BIT_CFG_PRIORITY   = 0;
  localparam int BIT_CFG_EXT_BUS    = 1;
  // reset values
  localparam logic [7:0] RST_CTRL_STAT  = 8'h00;
  localparam logic [7:0] RST_DATA       = 8'h00;
  localparam logic [2:0] RST_IRQ        = 3'h0;
  localparam logic [2:0] RST_STROBE_DIR = 3'h0;
  localparam logic [1:0] RST_CONFIG     = 2'h0;
  localparam logic [2:0] STROBE_DIR_INPUT = 3'h7;
  // link states, gray along idle -> write -> read
  typedef enum logic [1:0] {
    SPSLV_IDLE  = 2'b00,
    SPSLV_WRITE = 2'b01,
    SPSLV_READ  = 2'b11
  } spslv_state_t;
endpackage

// ### testbench/spslv_ext_master.sv
/*
  external 8-bit master model: drives chip select, read and write strobes
  and the data pins of the slave port.
  assumes its clock is the slave's sys_clk_i and strobes move after edges.
*/
`timescale 1ns/100ps
module spslv_ext_master (
  // clock
  input  wire logic       sys_clk_i,
  // strobes and data towards the slave
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic      [7:0] pd_o,
  // data from the slave
  input  wire logic [7:0] pd_i,
  input  wire logic       pd_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    pd_o   = 8'h00;
  end
  // strobes and data held low and stable for the whole write
  task automatic ext_write(input logic [7:0] v, input int hold);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    pd_o   <= v;
    repeat (hold) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    pd_o   <= ~v;
    @(posedge sys_clk_i);
  endtask
  // read strobes held low, data taken at the last edge before release
  task automatic ext_read(output logic [7:0] v, input int hold);
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    pd_o   <= ~pd_o;
    repeat (hold) @(posedge sys_clk_i);
    // undriven pins read as the inverse of the last value
    v = pd_oe_i ? pd_i : ~pd_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    @(posedge sys_clk_i);
  endtask
endmodule

// ### testbench/testbench.sv
/*
  self-checking bench for the parallel slave port core.
  assumes the core answers wishbone requests and the external master model.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic        pin_oe;
  logic        irq;
  logic        irq_hp;
  logic [7:0]  v;
  int          err_total;
  int          n_compared;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  spslv_top i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .pd_i(pin_in),
    .pd_o(pin_out), .pd_oe_o(pin_oe), .irq_o(irq), .irq_high_prio_o(irq_hp));
  spslv_ext_master i_mst (.sys_clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .pd_o(pin_in), .pd_i(pin_out), .pd_oe_i(pin_oe));
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic t_reset_and_off();
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    i_mst.ext_write(8'h11, 2);
    i_mst.ext_read(v, 2);
    `CHK(v, 8'hff)
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0000);
  endtask
  task automatic t_setup_extbus();
    wr(8'h10, 32'h7);
    rchk(8'h10, 32'h0000_0007);
    wr(8'h00, 32'h10);
    wr(8'h0c, 32'h1);
    wr(8'h14, 32'h2);
    i_mst.ext_write(8'h22, 2);
    rchk(8'h00, 32'h0000_0010);
    wr(8'h14, 32'h1);
  endtask
  task automatic t_write_overflow();
    i_mst.ext_write(8'ha5, 2);
    rchk(8'h08, 32'h0000_0001);
    rchk(8'h00, 32'h0000_0090);
    `CHK(irq, 1'b1)
    `CHK(irq_hp, 1'b1)
    i_mst.ext_write(8'hc3, 3);
    rchk(8'h00, 32'h0000_00b0);
    rchk(8'h04, 32'h0000_00c3);
    rchk(8'h00, 32'h0000_0030);
    wr(8'h08, 32'h7);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(irq_hp, 1'b0)
    wr(8'h00, 32'h10);
    rchk(8'h00, 32'h0000_0010);
  endtask
  task automatic t_read();
    wr(8'h04, 32'h3c);
    fork
      i_mst.ext_read(v, 16);
      begin
        repeat (4) @(posedge clk);
        `CHK(pin_oe, 1'b1)
        `CHK(pin_out, 8'h3c)
        rchk(8'h00, 32'h0000_0050);
        wr(8'h04, 32'h77);
        repeat (2) @(posedge clk);
        `CHK(pin_out, 8'h77)
      end
    join
    `CHK(v, 8'h77)
    repeat (2) @(posedge clk);
    `CHK(pin_oe, 1'b0)
    rchk(8'h08, 32'h0000_0002);
    rchk(8'h00, 32'h0000_0010);
  endtask
  initial begin
    err_total  = 0;
    n_compared = 0;
    rst_n = 1'b0;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    wdat  = 32'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_and_off();
    t_setup_extbus();
    t_write_overflow();
    t_read();
    summarize();
  end
endmodule
